// File: dv/bss_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module bss_flash_model #(
	parameter int DELAY = 5
) (
	input wire logic clk_i,
	input wire logic cold_rst_i,
	input wire logic image_ok_i,
	output logic done_o,
	output logic valid_o,
	output logic user_mode_o,
	output logic fallback_o
);
	logic [7:0] cnt;
	always_ff @(posedge clk_i) begin
		if (cold_rst_i) begin
			cnt <= 8'h00;
		end else if (cnt != 8'hFF) begin
			cnt <= cnt + 8'h01;
		end
	end
	// Image search result; valid is noise until done
	assign done_o = (cnt >= 8'(DELAY));
	assign valid_o = done_o ? image_ok_i : cnt[0];
	// Fabric already programmed when we leave reset
	assign user_mode_o = 1'b1;
	assign fallback_o = 1'b1;
endmodule
`default_nettype wire

// File: dv/tb_boot_source_select.sv
`timescale 1ns/100ps
`default_nettype none
module tb_boot_source_select;
	import bss_pkg::*;
	logic clk, rst, cold, warm, ram_req, ram_ok, img_ok, pre, rel;
	logic done, valid, user, fb, byp, pcfg, sec, rom, hit, remap, ws, fram, ffab, retain, pins;
	logic cfg_seen;
	logic [2:0] straps, field, code;
	logic [1:0] clock_select_straps, psel;
	logic [35:0] fetch;
	bss_src_e src;
	logic [21:0] mcfg, mout, mbid, mpull, em, eo, eb, ep;
	logic [11:0] fcfg, fout, fbid, fpull, fm, fo, fd, fp;
	int failures, check_count;

	bss_flash_model i_flash (.clk_i(clk), .cold_rst_i(cold), .image_ok_i(img_ok),
		.done_o(done), .valid_o(valid), .user_mode_o(user), .fallback_o(fb));

	bss_boot_select i_dut (.CLK_I(clk), .RST_I(rst), .COLD_RST_I(cold), .WARM_RST_I(warm),
		.BOOT_SELECT_STRAPS_I(straps), .CLOCK_SELECT_STRAPS_I(clock_select_straps), .RAM_BOOT_REQ_I(ram_req),
		.RAM_BOOT_VALID_I(ram_ok), .FABRIC_USER_MODE_I(user), .FLASH_IMAGE_DONE_I(done),
		.FLASH_IMAGE_VALID_I(valid), .FABRIC_FALLBACK_I(fb), .PRELOADER_START_I(pre),
		.SECONDARY_RELEASE_I(rel), .FETCH_ADDR_I(fetch), .BOOT_SELECT_FIELD_O(field),
		.BOOT_SOURCE_O(src), .PLL_BYPASS_O(byp), .PLL_CONFIG_O(pcfg), .PLL_CLOCK_SEL_O(psel),
		.SECONDARY_RESET_O(sec), .ROM_ENABLE_O(rom), .ROM_HIT_O(hit), .VECTOR_REMAP_O(remap),
		.WORKSPACE_RESERVED_O(ws), .RUN_FROM_RAM_O(fram), .RUN_FROM_FABRIC_O(ffab),
		.RETAIN_REGS_O(retain), .BOOT_PINS_ACTIVE_O(pins), .MIX_CFG_O(mcfg), .MIX_OUT_O(mout),
		.MIX_BIDIR_O(mbid), .MIX_PULL_O(mpull), .FLASH_CFG_O(fcfg), .FLASH_OUT_O(fout),
		.FLASH_BIDIR_O(fbid), .FLASH_PULL_O(fpull));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic summarize();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [35:0] got, input logic [35:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic wait_user();
		int i;
		i = 0;
		while (rom !== 1'b0 && i < 200) begin
			@(negedge clk);
			i++;
		end
		if (i >= 200) begin
			failures++;
			$display("MISMATCH t=%0t boot never left ROM", $time);
			summarize();
		end
	endtask

	task automatic cold_boot(input logic [2:0] c, input logic ok);
		straps = c;
		img_ok = ok;
		cold = 1'b1;
		repeat (2) @(negedge clk);
		cold = 1'b0;
		@(negedge clk);
		cfg_seen = pcfg;
		@(negedge clk);
	endtask

	initial begin
		{failures, check_count} = '0;
		{warm, ram_req, ram_ok, pre, rel} = '0;
		{rst, cold, img_ok} = 3'h7;
		straps = 3'h0;
		clock_select_straps = 2'h2;
		fetch = 36'h0_0000_0000;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		for (int c = 0; c < 8; c++) begin
			code = 3'(c);
			clock_select_straps = code[1:0];
			fetch = code[0] ? BSS_ROM_BASE : BSS_ROM_BASE + BSS_ROM_SIZE;
			cold_boot(code, 1'b1);
			{em, eo, eb, ep} = '0;
			{fm, fo, fd, fp} = '0;
			case (code)
				BSS_SEL_NAND18, BSS_SEL_NAND33: begin
					em = 22'h00_7FFF;
					eo = 22'h00_600F;
					eb = 22'h00_1FE0;
					ep = (code == BSS_SEL_NAND33) ? BSS_NAND33_PULL : 22'h00_0000;
				end
				BSS_SEL_SD18, BSS_SEL_SD33: begin
					fm = 12'h205;
					fo = 12'h200;
					fd = 12'h005;
					fp = 12'hDFA;
				end
				BSS_SEL_QSPI18, BSS_SEL_QSPI33: begin
					em = 22'h1F_8000;
					eo = 22'h18_0000;
					eb = 22'h07_8000;
					ep = 22'h28_0000;
				end
				default: begin
				end
			endcase
			chk("field", 36'(field), 36'(code));
			chk("source", 36'(src), 36'(c < 2 ? c : 2 + (c - 2) / 2));
			chk("bypass", 36'(byp), 36'(code == BSS_SEL_FPGA));
			chk("clksel", 36'(psel), 36'(c == 1 ? 2'h0 : clock_select_straps));
			chk("pllcfg", 36'(cfg_seen), 36'(c >= 2));
			chk("mixcfg", 36'(mcfg), 36'(em));
			chk("mixout", 36'(mout), 36'(eo));
			chk("mixbid", 36'(mbid), 36'(eb));
			chk("mixpull", 36'(mpull), 36'(ep));
			chk("flcfg", 36'(fcfg), 36'(fm));
			chk("flout", 36'(fout), 36'(fo));
			chk("flbid", 36'(fbid), 36'(fd));
			chk("flpull", 36'(fpull), 36'(fp));
			chk("hit", 36'(hit), 36'(code[0]));
			chk("work", 36'(ws), 36'(c >= 2));
			chk("sec", 36'(sec), 36'h1);
			chk("romen", 36'(rom), 36'h1);
			wait_user();
			chk("remap", 36'(remap), 36'h1);
			chk("fabric", 36'(ffab), 36'(c < 2));
			chk("sechold", 36'(sec), 36'h1);
			pre = 1'b1;
			@(negedge clk);
			pre = 1'b0;
			@(negedge clk);
			chk("pins", 36'(pins), 36'h0);
			chk("userpins", 36'({mcfg, fcfg}), 36'h0);
			rel = 1'b1;
			@(negedge clk);
			rel = 1'b0;
			@(negedge clk);
			chk("secrel", 36'(sec), 36'h0);
		end
		cold_boot(BSS_SEL_QSPI33, 1'b0);
		wait_user();
		chk("fallback", 36'(ffab), 36'h1);
		straps = BSS_SEL_NAND18;
		{ram_req, ram_ok, warm} = 3'h7;
		repeat (2) @(negedge clk);
		warm = 1'b0;
		repeat (3) @(negedge clk);
		wait_user();
		chk("warmfield", 36'(field), 36'(BSS_SEL_QSPI33));
		chk("retain", 36'(retain), 36'h1);
		chk("ramrun", 36'(fram), 36'h1);
		chk("warmpins", 36'(pins), 36'h0);
		summarize();
	end
endmodule
`default_nettype wire

// File: hdl/bss_boot_select.sv
`timescale 1ns/100ps
`default_nettype none
module bss_boot_select
	import bss_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic COLD_RST_I,
	input wire logic WARM_RST_I,
	input wire logic [2:0] BOOT_SELECT_STRAPS_I,
	input wire logic [1:0] CLOCK_SELECT_STRAPS_I,
	input wire logic RAM_BOOT_REQ_I,
	input wire logic RAM_BOOT_VALID_I,
	input wire logic FABRIC_USER_MODE_I,
	input wire logic FLASH_IMAGE_DONE_I,
	input wire logic FLASH_IMAGE_VALID_I,
	input wire logic FABRIC_FALLBACK_I,
	input wire logic PRELOADER_START_I,
	input wire logic SECONDARY_RELEASE_I,
	input wire logic [35:0] FETCH_ADDR_I,
	output logic [2:0] BOOT_SELECT_FIELD_O,
	output var bss_pkg::bss_src_e BOOT_SOURCE_O,
	output logic PLL_BYPASS_O,
	output logic PLL_CONFIG_O,
	output logic [1:0] PLL_CLOCK_SEL_O,
	output logic SECONDARY_RESET_O,
	output logic ROM_ENABLE_O,
	output logic ROM_HIT_O,
	output logic VECTOR_REMAP_O,
	output logic WORKSPACE_RESERVED_O,
	output logic RUN_FROM_RAM_O,
	output logic RUN_FROM_FABRIC_O,
	output logic RETAIN_REGS_O,
	output logic BOOT_PINS_ACTIVE_O,
	output logic [bss_pkg::BSS_MIX_PINS-1:0] MIX_CFG_O,
	output logic [bss_pkg::BSS_MIX_PINS-1:0] MIX_OUT_O,
	output logic [bss_pkg::BSS_MIX_PINS-1:0] MIX_BIDIR_O,
	output logic [bss_pkg::BSS_MIX_PINS-1:0] MIX_PULL_O,
	output logic [bss_pkg::BSS_FLASH_PINS-1:0] FLASH_CFG_O,
	output logic [bss_pkg::BSS_FLASH_PINS-1:0] FLASH_OUT_O,
	output logic [bss_pkg::BSS_FLASH_PINS-1:0] FLASH_BIDIR_O,
	output logic [bss_pkg::BSS_FLASH_PINS-1:0] FLASH_PULL_O
);
	import bss_pkg::*;

	typedef enum logic [2:0] {
		ST_RESET, ST_ROM, ST_WAIT_FABRIC, ST_LOAD_FLASH, ST_USER
	} bss_state_e;

	logic cold_q;
	logic warm_q;
	logic [2:0] sel;
	logic [1:0] clock_select_straps;
	logic warm_ram;
	logic secondary_held;
	logic user_regs;
	logic from_ram;
	logic from_fabric;
	bss_state_e state;
	bss_state_e next_state;

	wire cold_release = cold_q && !COLD_RST_I;
	wire any_rst = RST_I || COLD_RST_I || WARM_RST_I;
	wire warm_release = warm_q && !WARM_RST_I && !COLD_RST_I;
	wire is_fpga = sel == BSS_SEL_FPGA;
	wire is_flash = sel != BSS_SEL_FPGA && sel != BSS_SEL_RSVD;
	wire fallback = FABRIC_FALLBACK_I && FABRIC_USER_MODE_I;

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			cold_q <= 1'b1;
			warm_q <= 1'b0;
		end else begin
			cold_q <= COLD_RST_I;
			warm_q <= WARM_RST_I;
		end
	end

	// Straps caught only on cold release
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			sel <= BSS_SEL_RST;
			clock_select_straps <= 2'h0;
		end else if (cold_release) begin
			sel <= BOOT_SELECT_STRAPS_I;
			clock_select_straps <= CLOCK_SELECT_STRAPS_I;
		end
	end

	// Warm RAM boot bypasses the strap choice
	always_ff @(posedge CLK_I) begin
		if (RST_I || COLD_RST_I) begin
			warm_ram <= 1'b0;
		end else if (warm_release) begin
			warm_ram <= RAM_BOOT_REQ_I;
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			ST_RESET: begin
				if (cold_release || warm_release) begin
					next_state = ST_ROM;
				end
			end
			ST_ROM: begin
				if (warm_ram && RAM_BOOT_VALID_I) begin
					next_state = ST_USER;
				end else if (warm_ram || !is_flash) begin
					next_state = ST_WAIT_FABRIC;
				end else begin
					next_state = ST_LOAD_FLASH;
				end
			end
			ST_LOAD_FLASH: begin
				if (FLASH_IMAGE_DONE_I && FLASH_IMAGE_VALID_I) begin
					next_state = ST_USER;
				end else if (FLASH_IMAGE_DONE_I) begin
					next_state = ST_WAIT_FABRIC;
				end
			end
			ST_WAIT_FABRIC: begin
				if (is_fpga && FABRIC_USER_MODE_I && !warm_ram) begin
					next_state = ST_USER;
				end else if (fallback) begin
					next_state = ST_USER;
				end
			end
			default: begin
				next_state = ST_USER;
			end
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (any_rst) begin
			state <= ST_RESET;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (any_rst) begin
			from_ram <= 1'b0;
			from_fabric <= 1'b0;
		end else if (next_state == ST_USER && state != ST_USER) begin
			from_ram <= state == ST_ROM;
			from_fabric <= state == ST_WAIT_FABRIC;
		end
	end

	// Preloader start hands pins to user settings
	always_ff @(posedge CLK_I) begin
		if (any_rst) begin
			user_regs <= 1'b0;
		end else if (state == ST_USER && PRELOADER_START_I) begin
			user_regs <= 1'b1;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (any_rst) begin
			secondary_held <= 1'b1;
		end else if (state == ST_USER && SECONDARY_RELEASE_I) begin
			secondary_held <= 1'b0;
		end
	end

	wire in_rom = state != ST_USER;
	wire rom_hit = FETCH_ADDR_I >= BSS_ROM_BASE
		&& FETCH_ADDR_I < BSS_ROM_BASE + BSS_ROM_SIZE;
	wire vec_hit = FETCH_ADDR_I < BSS_VEC_BASE + BSS_VEC_SPAN;

	assign BOOT_SELECT_FIELD_O = sel;
	assign BOOT_SOURCE_O = sel == BSS_SEL_FPGA ? BSS_SRC_FPGA
		: (sel == BSS_SEL_NAND18 || sel == BSS_SEL_NAND33) ? BSS_SRC_NAND
		: (sel == BSS_SEL_SD18 || sel == BSS_SEL_SD33) ? BSS_SRC_SD
		: (sel == BSS_SEL_QSPI18 || sel == BSS_SEL_QSPI33) ? BSS_SRC_QSPI
		: BSS_SRC_NONE;
	assign PLL_BYPASS_O = is_fpga;
	assign PLL_CONFIG_O = is_flash && state == ST_ROM;
	assign PLL_CLOCK_SEL_O = is_fpga ? 2'h0 : clock_select_straps;
	assign SECONDARY_RESET_O = secondary_held;
	assign ROM_ENABLE_O = in_rom;
	assign ROM_HIT_O = in_rom && (rom_hit || vec_hit);
	assign VECTOR_REMAP_O = !in_rom;
	assign WORKSPACE_RESERVED_O = in_rom && is_flash && !warm_ram;
	assign RUN_FROM_RAM_O = from_ram;
	assign RUN_FROM_FABRIC_O = from_fabric;
	assign RETAIN_REGS_O = warm_ram;
	assign BOOT_PINS_ACTIVE_O = !user_regs && !warm_ram;

	bss_pin_route u_route (
		.sel_i(sel),
		.boot_pins_i(BOOT_PINS_ACTIVE_O),
		.mix_cfg_o(MIX_CFG_O),
		.mix_out_o(MIX_OUT_O),
		.mix_bidir_o(MIX_BIDIR_O),
		.mix_pull_o(MIX_PULL_O),
		.fl_cfg_o(FLASH_CFG_O),
		.fl_out_o(FLASH_OUT_O),
		.fl_bidir_o(FLASH_BIDIR_O),
		.fl_pull_o(FLASH_PULL_O)
	);

	AST_CAPTURE: assert property (@(posedge CLK_I) disable iff (RST_I)
		cold_release |=> sel == $past(BOOT_SELECT_STRAPS_I))
		else $error("strap not captured");
	AST_STABLE: assert property (@(posedge CLK_I) disable iff (RST_I)
		!cold_release |=> $stable(sel))
		else $error("boot select changed without cold release");
	AST_FPGA_BYPASS: assert property (@(posedge CLK_I) disable iff (RST_I)
		is_fpga |-> PLL_BYPASS_O && PLL_CLOCK_SEL_O == 2'h0 && MIX_CFG_O == '0)
		else $error("fabric boot without bypass");
	AST_SECONDARY: assert property (@(posedge CLK_I) disable iff (RST_I)
		in_rom |-> SECONDARY_RESET_O)
		else $error("secondary core released during rom");
	AST_ROM_OFF: assert property (@(posedge CLK_I) disable iff (RST_I)
		state == ST_USER |-> !ROM_ENABLE_O && VECTOR_REMAP_O)
		else $error("rom still enabled in user code");
	AST_FABRIC_WAIT: assert property (@(posedge CLK_I) disable iff (any_rst)
		$rose(RUN_FROM_FABRIC_O) |-> $past(FABRIC_USER_MODE_I))
		else $error("fabric handoff before user mode");
	AST_WORKSPACE: assert property (@(posedge CLK_I) disable iff (RST_I)
		(is_fpga || warm_ram) |-> !WORKSPACE_RESERVED_O)
		else $error("workspace reserved wrongly");
	AST_QSPI_PINS: assert property (@(posedge CLK_I) disable iff (RST_I)
		(sel == BSS_SEL_QSPI33 && BOOT_PINS_ACTIVE_O) |->
		MIX_BIDIR_O[18:15] == 4'hF && MIX_PULL_O[21] && !MIX_CFG_O[21])
		else $error("quad pins wrong");
	AST_SD_PINS: assert property (@(posedge CLK_I) disable iff (RST_I)
		(sel == BSS_SEL_SD33 && BOOT_PINS_ACTIVE_O) |->
		FLASH_OUT_O[9] && FLASH_BIDIR_O[0] && FLASH_PULL_O[1] && !FLASH_CFG_O[1])
		else $error("card pins wrong");
	AST_USER_PINS: assert property (@(posedge CLK_I) disable iff (any_rst)
		user_regs |-> MIX_CFG_O == '0 && FLASH_CFG_O == '0)
		else $error("boot pins after preloader");
	AST_ROM_ENTRY: assert property (@(posedge CLK_I) disable iff (any_rst)
		(state == ST_RESET && (cold_release || warm_release)) |=> state == ST_ROM)
		else $error("reset exit did not enter rom");
	AST_LOAD_WAIT: assert property (@(posedge CLK_I) disable iff (any_rst)
		(state == ST_LOAD_FLASH && FLASH_IMAGE_DONE_I && !FLASH_IMAGE_VALID_I) |=> state == ST_WAIT_FABRIC)
		else $error("bad flash image did not seek fallback");
	AST_FLASH_FALLBACK: assert property (@(posedge CLK_I) disable iff (any_rst)
		($rose(RUN_FROM_FABRIC_O) && !is_fpga) |-> $past(FABRIC_FALLBACK_I))
		else $error("fabric run without fallback image");
	AST_RAM_RUN: assert property (@(posedge CLK_I) disable iff (any_rst)
		$rose(RUN_FROM_RAM_O) |-> RETAIN_REGS_O && $past(RAM_BOOT_VALID_I))
		else $error("ram run without valid warm ram boot");
	AST_WARM_NO_PINS: assert property (@(posedge CLK_I) disable iff (RST_I)
		RETAIN_REGS_O |-> !BOOT_PINS_ACTIVE_O && MIX_CFG_O == '0 && FLASH_CFG_O == '0)
		else $error("boot pins driven on warm ram boot");
	AST_SECONDARY_HOLD: assert property (@(posedge CLK_I) disable iff (any_rst)
		$fell(SECONDARY_RESET_O) |-> $past(SECONDARY_RELEASE_I) && $past(state == ST_USER))
		else $error("secondary released without request");
	AST_PLL_CONFIG: assert property (@(posedge CLK_I) disable iff (RST_I)
		PLL_CONFIG_O |-> !PLL_BYPASS_O && PLL_CLOCK_SEL_O == clock_select_straps)
		else $error("pll setup not from clock straps");
	AST_FABRIC_SRC: assert property (@(posedge CLK_I) disable iff (RST_I)
		is_fpga |-> BOOT_SOURCE_O == BSS_SRC_FPGA && FLASH_CFG_O == '0 && BOOT_SELECT_FIELD_O == BSS_SEL_FPGA)
		else $error("fabric boot source wrong");
	AST_NAND_PINS: assert property (@(posedge CLK_I) disable iff (RST_I)
		((sel == BSS_SEL_NAND18 || sel == BSS_SEL_NAND33) && BOOT_PINS_ACTIVE_O) |->
		MIX_CFG_O[14:0] == 15'h7FFF && MIX_BIDIR_O[12:5] == 8'hFF && !MIX_OUT_O[4] && MIX_CFG_O[21:15] == 7'h00)
		else $error("nand pins wrong");
	AST_QSPI18_PINS: assert property (@(posedge CLK_I) disable iff (RST_I)
		(sel == BSS_SEL_QSPI18 && BOOT_PINS_ACTIVE_O) |->
		MIX_OUT_O[20:19] == 2'h3 && MIX_PULL_O[19] && MIX_PULL_O[21] && !MIX_CFG_O[21])
		else $error("low voltage quad pins wrong");
	AST_SD18_PINS: assert property (@(posedge CLK_I) disable iff (RST_I)
		(sel == BSS_SEL_SD18 && BOOT_PINS_ACTIVE_O) |->
		FLASH_CFG_O == 12'h205 && FLASH_PULL_O[8] && MIX_CFG_O == '0)
		else $error("low voltage card pins wrong");
	AST_ROM_LOCKED: assert property (@(posedge CLK_I) disable iff (RST_I)
		!in_rom |-> !ROM_HIT_O)
		else $error("rom reachable from user code");
	COV_FLASH: cover property (@(posedge CLK_I) state == ST_LOAD_FLASH ##1 state == ST_USER);
	COV_FALLBACK: cover property (@(posedge CLK_I) state == ST_LOAD_FLASH ##1 state == ST_WAIT_FABRIC);
	COV_WARM_RAM: cover property (@(posedge CLK_I) warm_ram && RUN_FROM_RAM_O);
	COV_SECOND: cover property (@(posedge CLK_I) $fell(SECONDARY_RESET_O));
	COV_FABRIC: cover property (@(posedge CLK_I) state == ST_WAIT_FABRIC && is_fpga ##1 state == ST_USER);
endmodule
`default_nettype wire

// File: hdl/bss_pin_route.sv
`timescale 1ns/100ps
`default_nettype none
module bss_pin_route
	import bss_pkg::*;
(
	input wire logic [2:0] sel_i,
	input wire logic boot_pins_i,
	output logic [bss_pkg::BSS_MIX_PINS-1:0] mix_cfg_o,
	output logic [bss_pkg::BSS_MIX_PINS-1:0] mix_out_o,
	output logic [bss_pkg::BSS_MIX_PINS-1:0] mix_bidir_o,
	output logic [bss_pkg::BSS_MIX_PINS-1:0] mix_pull_o,
	output logic [bss_pkg::BSS_FLASH_PINS-1:0] fl_cfg_o,
	output logic [bss_pkg::BSS_FLASH_PINS-1:0] fl_out_o,
	output logic [bss_pkg::BSS_FLASH_PINS-1:0] fl_bidir_o,
	output logic [bss_pkg::BSS_FLASH_PINS-1:0] fl_pull_o
);
	wire is_nand = boot_pins_i && (sel_i == BSS_SEL_NAND18 || sel_i == BSS_SEL_NAND33);
	wire is_sd = boot_pins_i && (sel_i == BSS_SEL_SD18 || sel_i == BSS_SEL_SD33);
	wire is_qspi = boot_pins_i && (sel_i == BSS_SEL_QSPI18 || sel_i == BSS_SEL_QSPI33);
	wire is_n33 = sel_i == BSS_SEL_NAND33;
	genvar g;
	generate
		for (g = 0; g < BSS_MIX_PINS; g++) begin : g_mix
			localparam bit NAND = g <= BSS_NAND_LAST;
			localparam bit NDQ = g > BSS_NAND_RB && g < BSS_NAND_LAST - 1;
			localparam bit QIO = g >= BSS_QSPI_FIRST && g <= BSS_QSPI_IO_LAST;
			localparam bit QOUT = g == BSS_QUAD_SELECT0 || g == BSS_QSPI_CLK;
			assign mix_cfg_o[g] = (is_nand && NAND) || (is_qspi && (QIO || QOUT));
			assign mix_bidir_o[g] = (is_nand && NDQ) || (is_qspi && QIO);
			assign mix_out_o[g] = (is_nand && NAND && !NDQ && g != BSS_NAND_RB) || (is_qspi && QOUT);
			assign mix_pull_o[g] = (is_nand && is_n33 && BSS_NAND33_PULL[g])
				|| (is_qspi && (g == BSS_QUAD_SELECT0 || g == BSS_QUAD_SELECT1));
		end
		for (g = 0; g < BSS_FLASH_PINS; g++) begin : g_fl
			localparam bit BI = g == BSS_SD_CMD || g == BSS_SD_D0;
			assign fl_cfg_o[g] = is_sd && (BI || g == BSS_SD_CLK);
			assign fl_bidir_o[g] = is_sd && BI;
			assign fl_out_o[g] = is_sd && g == BSS_SD_CLK;
			assign fl_pull_o[g] = is_sd && !(BI || g == BSS_SD_CLK);
		end
	endgenerate
endmodule
`default_nettype wire

// File: hdl/bss_pkg.sv
package bss_pkg;
	// Strap codes
	localparam logic [2:0] BSS_SEL_RSVD = 3'h0;
	localparam logic [2:0] BSS_SEL_FPGA = 3'h1;
	localparam logic [2:0] BSS_SEL_NAND18 = 3'h2;
	localparam logic [2:0] BSS_SEL_NAND33 = 3'h3;
	localparam logic [2:0] BSS_SEL_SD18 = 3'h4;
	localparam logic [2:0] BSS_SEL_SD33 = 3'h5;
	localparam logic [2:0] BSS_SEL_QSPI18 = 3'h6;
	localparam logic [2:0] BSS_SEL_QSPI33 = 3'h7;
	localparam logic [2:0] BSS_SEL_RST = 3'h0;
	// Pin banks
	localparam int BSS_MIX_PINS = 22;
	localparam int BSS_FLASH_PINS = 12;
	localparam int BSS_NAND_FIRST = 0;
	localparam int BSS_NAND_LAST = 14;
	localparam int BSS_NAND_RB = 4;
	localparam int BSS_QSPI_FIRST = 15;
	localparam int BSS_QSPI_IO_LAST = 18;
	localparam int BSS_QUAD_SELECT0 = 19;
	localparam int BSS_QSPI_CLK = 20;
	localparam int BSS_QUAD_SELECT1 = 21;
	localparam int BSS_SD_CMD = 0;
	localparam int BSS_SD_D0 = 2;
	localparam int BSS_SD_CLK = 9;
	// NAND pins with pull-up at 3.3 V: CE, RE, WP, WE
	localparam logic [21:0] BSS_NAND33_PULL = 22'h00_600A;
	// Memory map
	localparam logic [35:0] BSS_ROM_BASE = 36'hF_FFFD_0000;
	localparam int BSS_ROM_KB = 64;
	localparam int BSS_WORKSPACE_KB = 4;
	localparam logic [35:0] BSS_ROM_SIZE = 36'(BSS_ROM_KB * 1024);
	localparam logic [35:0] BSS_VEC_BASE = 36'h0_0000_0000;
	localparam logic [35:0] BSS_VEC_SPAN = 36'h0_0000_0040;
	typedef enum logic [2:0] {
		BSS_SRC_NONE,
		BSS_SRC_FPGA,
		BSS_SRC_NAND,
		BSS_SRC_SD,
		BSS_SRC_QSPI
	} bss_src_e;
endpackage
